/* File: design/eeprom_pkg.sv */
// Constants, encodings and timing for the two-wire EEPROM front end.
// Assumes a single 250 MHz system clock that samples both bus lines.

package eeprom_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int WR_TIME_MS = 5;
    // Longest time, so rounded down
    localparam int WR_CYCLES = WR_TIME_MS * 1000 * CLK_MHZ;
    localparam int STD_KHZ = 100;
    localparam int FAST_KHZ = 400;
    localparam int FASTPLUS_KHZ = 1000;
    // Shortest clock half-period in system cycles at the top bus rate
    localparam int SCL_HALF_CYCLES = (CLK_MHZ * 1000) / (2 * FASTPLUS_KHZ);

    // ------------------------------------------------------------------
    // Array, page and serial number
    // ------------------------------------------------------------------
    localparam int MEM_DEPTH_SMALL = 128;
    localparam int MEM_DEPTH_LARGE = 256;
    localparam int PAGE_BYTES = 8;
    localparam int FIFO_DEPTH = PAGE_BYTES;
    localparam int FIFO_WIDTH = 16;
    localparam int SN_BITS = 128;
    localparam logic [7:0] SMALL_ADDR_MASK = 8'h7F;
    localparam logic [7:0] LARGE_ADDR_MASK = 8'hFF;

    // ------------------------------------------------------------------
    // Address byte fields
    // ------------------------------------------------------------------
    localparam logic [3:0] MEM_TYPE = 4'hA;
    localparam logic [3:0] SN_TYPE = 4'hB;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] LINE_SYNC_RST = 2'h3;
    localparam logic LINE_RST = 1'h1;
    localparam logic [1:0] PIN_SYNC_RST = 2'h0;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_DEVADR  = 7'h02,
        ST_WORDADR = 7'h04,
        ST_WRDATA  = 7'h08,
        ST_ACK     = 7'h10,
        ST_RDDATA  = 7'h20,
        ST_RDACK   = 7'h40
    } phase_t;

endpackage

/* File: design/two_wire_eeprom_pin_front_end.sv */
// Two-wire serial EEPROM slave: pins, protocol, page buffer and array.
// Assumes bus lines arrive asynchronously and the pads pull straps low.

`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Page buffer FIFO
// ----------------------------------------------------------------------
module page_fifo #(
    parameter int width = 16,
    parameter int depth = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int PW = $clog2(depth);

    logic [width-1:0] slots [depth];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic do_push;
    logic do_pop;

    assign in_ready = (count != (PW+1)'(depth));
    assign out_valid = (count != '0);
    assign out_data = slots[rd_ptr];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (do_push) begin
            slots[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= PW'(wr_ptr + 1'b1);
            end
            if (do_pop) begin
                rd_ptr <= PW'(rd_ptr + 1'b1);
            end
            count <= (PW+1)'(count + do_push - do_pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// Slave front end
// ----------------------------------------------------------------------
module two_wire_eeprom_pin_front_end #(
    parameter logic small_variant = 1'h0,
    parameter int prog_cycles = eeprom_pkg::WR_CYCLES,
    // Arbitrary neutral value
    parameter logic [127:0] serial_number =
        128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic write_protect,
    output logic write_busy
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wp_sync;
    logic [1:0] strap0_sync;
    logic [1:0] strap1_sync;
    logic [1:0] strap2_sync;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic wp;
    logic [2:0] strap;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    eeprom_pkg::phase_t phase;
    eeprom_pkg::phase_t ack_next;
    logic [3:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [7:0] addr;
    logic sel_sn;
    logic byte_done;
    logic dev_hit;
    logic accept;
    logic push_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic pending;
    logic [31:0] prog_timer;
    logic [7:0] mem [eeprom_pkg::MEM_DEPTH_LARGE];
    logic [127:0] sn_shift;
    logic [7:0] rd_byte;

    function automatic logic [7:0] mask_addr(input logic [7:0] a);
        return a & (small_variant ? eeprom_pkg::SMALL_ADDR_MASK
                                  : eeprom_pkg::LARGE_ADDR_MASK);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Pads pull floating straps and protect low; reset also reads low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= eeprom_pkg::LINE_SYNC_RST;
            sda_sync <= eeprom_pkg::LINE_SYNC_RST;
            wp_sync <= eeprom_pkg::PIN_SYNC_RST;
            strap0_sync <= eeprom_pkg::PIN_SYNC_RST;
            strap1_sync <= eeprom_pkg::PIN_SYNC_RST;
            strap2_sync <= eeprom_pkg::PIN_SYNC_RST;
            scl_d <= eeprom_pkg::LINE_RST;
            sda_d <= eeprom_pkg::LINE_RST;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            wp_sync <= {wp_sync[0], write_protect};
            strap0_sync <= {strap0_sync[0], addr_strap_bit0};
            strap1_sync <= {strap1_sync[0], addr_strap_bit1};
            strap2_sync <= {strap2_sync[0], addr_strap_bit2};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign wp = wp_sync[1];
    assign strap = {strap2_sync[1], strap1_sync[1], strap0_sync[1]};
    // Idle clock held high by master keeps edges quiet here
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // ------------------------------------------------------------------
    // Byte decisions
    // ------------------------------------------------------------------
    assign byte_done = scl_fall & (bit_cnt == eeprom_pkg::BITS_PER_BYTE);
    assign dev_hit = ((sh_in[7:4] == eeprom_pkg::MEM_TYPE) |
                      (sh_in[7:4] == eeprom_pkg::SN_TYPE)) &
                     (sh_in[3:1] == strap) & ~write_busy;
    // Serial number region never takes data bytes
    assign accept = ~sel_sn & ~wp & fifo_in_ready;
    assign push_valid = (phase == eeprom_pkg::ST_WRDATA) & byte_done
                        & accept;
    assign sn_shift = serial_number << {addr[3:0], 3'h0};
    assign rd_byte = sel_sn ? sn_shift[127:120] : mem[mask_addr(addr)];
    // Open drain: only ever a low level, enable does the work
    assign sda_out = 1'h0;

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= eeprom_pkg::ST_IDLE;
            ack_next <= eeprom_pkg::ST_IDLE;
            bit_cnt <= eeprom_pkg::BIT_CNT_RST;
            sh_in <= eeprom_pkg::BYTE_RST;
            sh_out <= eeprom_pkg::BYTE_RST;
            addr <= eeprom_pkg::BYTE_RST;
            sel_sn <= 1'h0;
            sda_oe <= 1'h0;
        end else if (start_det) begin
            phase <= eeprom_pkg::ST_DEVADR;
            bit_cnt <= eeprom_pkg::BIT_CNT_RST;
            sda_oe <= 1'h0;
        end else if (stop_det) begin
            phase <= eeprom_pkg::ST_IDLE;
            sda_oe <= 1'h0;
        end else begin
            case (phase)
                eeprom_pkg::ST_DEVADR,
                eeprom_pkg::ST_WORDADR,
                eeprom_pkg::ST_WRDATA: begin
                    if (scl_rise &&
                        bit_cnt != eeprom_pkg::BITS_PER_BYTE) begin
                        sh_in <= {sh_in[6:0], sda_s};
                        bit_cnt <= 4'(bit_cnt + 1'b1);
                    end else if (byte_done) begin
                        bit_cnt <= eeprom_pkg::BIT_CNT_RST;
                        if (phase == eeprom_pkg::ST_DEVADR) begin
                            if (dev_hit) begin
                                sda_oe <= 1'h1;
                                phase <= eeprom_pkg::ST_ACK;
                                sel_sn <= (sh_in[7:4] ==
                                           eeprom_pkg::SN_TYPE);
                                ack_next <= sh_in[0] ?
                                    eeprom_pkg::ST_RDDATA :
                                    eeprom_pkg::ST_WORDADR;
                            end else begin
                                phase <= eeprom_pkg::ST_IDLE;
                            end
                        end else if (phase == eeprom_pkg::ST_WORDADR) begin
                            addr <= sh_in;
                            sda_oe <= 1'h1;
                            phase <= eeprom_pkg::ST_ACK;
                            ack_next <= eeprom_pkg::ST_WRDATA;
                        end else if (accept) begin
                            // Address wraps within the page; the full buffer refuses a ninth byte
                            addr <= {addr[7:3], 3'(addr[2:0] + 1'b1)};
                            sda_oe <= 1'h1;
                            phase <= eeprom_pkg::ST_ACK;
                            ack_next <= eeprom_pkg::ST_WRDATA;
                        end else begin
                            phase <= eeprom_pkg::ST_IDLE;
                        end
                    end
                end
                eeprom_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        phase <= ack_next;
                        if (ack_next == eeprom_pkg::ST_RDDATA) begin
                            sda_oe <= ~rd_byte[7];
                            sh_out <= {rd_byte[6:0], 1'h0};
                            bit_cnt <= 4'h1;
                            if (sel_sn) begin
                                addr <= {addr[7:4],
                                         4'(addr[3:0] + 1'b1)};
                            end else begin
                                addr <= mask_addr(8'(addr + 1'b1));
                            end
                        end else begin
                            sda_oe <= 1'h0;
                            bit_cnt <= eeprom_pkg::BIT_CNT_RST;
                        end
                    end
                end
                eeprom_pkg::ST_RDDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == eeprom_pkg::BITS_PER_BYTE) begin
                            sda_oe <= 1'h0;
                            phase <= eeprom_pkg::ST_RDACK;
                        end else begin
                            sda_oe <= ~sh_out[7];
                            sh_out <= {sh_out[6:0], 1'h0};
                            bit_cnt <= 4'(bit_cnt + 1'b1);
                        end
                    end
                end
                eeprom_pkg::ST_RDACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            phase <= eeprom_pkg::ST_ACK;
                            ack_next <= eeprom_pkg::ST_RDDATA;
                        end else begin
                            phase <= eeprom_pkg::ST_IDLE;
                        end
                    end
                end
                eeprom_pkg::ST_IDLE: begin
                    bit_cnt <= eeprom_pkg::BIT_CNT_RST;
                end
                default: begin
                    phase <= eeprom_pkg::ST_IDLE;
                    sda_oe <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Page buffer and self-timed programming
    // ------------------------------------------------------------------
    // Drain stalls until stop, so a full page back-pressures as a nack
    page_fifo #(
        .width(eeprom_pkg::FIFO_WIDTH),
        .depth(eeprom_pkg::FIFO_DEPTH)
    ) u_page (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data({addr, sh_in}),
        .out_valid(fifo_out_valid),
        .out_ready(write_busy),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_busy <= 1'h0;
            pending <= 1'h0;
            prog_timer <= eeprom_pkg::TIMER_RST;
        end else begin
            if (stop_det && pending && !write_busy) begin
                write_busy <= 1'h1;
                pending <= 1'h0;
                prog_timer <= eeprom_pkg::TIMER_RST;
            end else if (write_busy) begin
                prog_timer <= prog_timer + 32'h0000_0001;
                if (prog_timer >= 32'(prog_cycles - 1) &&
                    !fifo_out_valid) begin
                    write_busy <= 1'h0;
                end
            end
            if (push_valid) begin
                pending <= 1'h1;
            end
        end
    end

    // Array has no reset, as a real cell array would not
    always_ff @(posedge clk) begin
        if (write_busy && fifo_out_valid && !wp) begin
            mem[mask_addr(fifo_out_data[15:8])] <=
                fifo_out_data[7:0];
        end
    end
endmodule

/* File: tb/eeprom_fe_properties.sv */
// Pin-level assertions for the two-wire EEPROM front end.
// Assumes one clock; bus pins are the resolved wire levels.
`timescale 1ns/1ns

module eeprom_fe_properties #(
    parameter int prog_cycles = 50
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic write_protect,
    input wire logic write_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    logic [7:0] fall_age;
    logic [7:0] stop_age;
    logic [31:0] busy_cnt;
    wire scl_fall = scl_q & ~scl_in;
    wire bus_start = scl_q & scl_in & sda_q & ~sda_in;
    wire bus_stop = scl_q & scl_in & ~sda_q & sda_in;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Ages saturate so a long idle never wraps into a false match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fall_age <= 8'hFF;
        end else if (scl_fall) begin
            fall_age <= 8'h00;
        end else if (fall_age != 8'hFF) begin
            fall_age <= fall_age + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_age <= 8'hFF;
        end else if (bus_stop) begin
            stop_age <= 8'h00;
        end else if (stop_age != 8'hFF) begin
            stop_age <= stop_age + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt <= 32'h0000_0000;
        end else if (write_busy) begin
            busy_cnt <= busy_cnt + 32'h0000_0001;
        end else begin
            busy_cnt <= 32'h0000_0000;
        end
    end

    sequence busy_begin;
        $rose(write_busy);
    endsequence

    sequence busy_run;
        write_busy [*8];
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    drain_low_a: assert property (!sda_out)
        else $error("data pin output value not low");
    oe_after_fall_a: assert property ($changed(sda_oe) |->
        !scl_in && fall_age <= 8'h06)
        else $error("data drive changed away from a clock fall");
    oe_hold_high_a: assert property (scl_in && $past(scl_in, 4) |->
        $stable(sda_oe))
        else $error("data drive changed while clock high");
    start_quiet_a: assert property (bus_start |=> !sda_oe [*8])
        else $error("data driven right after a start");
    busy_after_stop_a: assert property (busy_begin |->
        stop_age <= 8'h08)
        else $error("programming began without a stop");
    busy_hold_a: assert property (busy_begin |=> busy_run)
        else $error("programming ended at once");
    busy_len_a: assert property ($fell(write_busy) |->
        busy_cnt >= prog_cycles - 1 && busy_cnt <= prog_cycles + 16)
        else $error("programming time out of range");
    busy_nack_a: assert property ($rose(sda_oe) |-> !write_busy)
        else $error("acknowledge while programming");
endmodule

bind two_wire_eeprom_pin_front_end eeprom_fe_properties #(
    .prog_cycles(prog_cycles)
) u_eeprom_fe_properties (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
    .addr_strap_bit2(addr_strap_bit2), .write_protect(write_protect),
    .write_busy(write_busy)
);

/* File: tb/i2c_master_model.sv */
// Bus master model for the two-wire EEPROM front end.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns

module i2c_master_model #(
    parameter int half_cycles = 30
) (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // ------------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Faster than fast-plus to keep the run short; the design needs >4 clks
    task automatic half();
        repeat (half_cycles) @(negedge clk);
    endtask

    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask

    // Leaves the clock high, as an idle bus needs
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask

    // Data held a half period past the fall so no false start is seen
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
        half();
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the two-wire EEPROM front end.
// Assumes the master model owns the clock line; the data wire is pulled up.
`timescale 1ns/1ns

module tb;
    localparam int prog = 3000;
    // Arbitrary value
    localparam logic [127:0] sn_value =
        128'h5A3C_96E1_0F78_C3A5_1E2D_B4F0_6987_D21B;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] strap = 3'h0;
    logic wp = 1'b0;
    logic scl;
    logic m_low;
    logic sda_out;
    logic sda_oe;
    logic write_busy;
    wire sda = ((sda_oe & ~sda_out) | m_low) ? 1'b0 : 1'b1;
    int err_total = 0;
    int checks = 0;
    logic [31:0] seed = 32'hF91ACFDA;
    int ref_mem [256];
    logic [7:0] pb;

    always #2 clk = ~clk;

    two_wire_eeprom_pin_front_end #(
        .small_variant(1'h0), .prog_cycles(prog), .serial_number(sn_value)
    ) u_two_wire_eeprom_pin_front_end (
        .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .write_protect(wp),
        .write_busy(write_busy)
    );

    i2c_master_model #(.half_cycles(30)) u_bus (
        .clk(clk), .scl(scl), .sda_low(m_low), .sda(sda)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic finish_test();
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 2 * prog) begin
            @(negedge clk);
            n++;
        end
        check("write_busy idle", 0, write_busy);
    endtask

    // Unknown (-1) entries mark bytes whose commit is not promised
    task automatic wr(input logic [3:0] kind, input logic [7:0] wa,
                      input int n, input int ok_n, input logic keep);
        logic ack;
        logic [7:0] d;
        logic [2:0] lo;
        u_bus.start();
        u_bus.wbyte({kind, strap, 1'b0}, ack);
        check("address ack", 1, ack);
        u_bus.wbyte(wa, ack);
        check("word ack", 1, ack);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            u_bus.wbyte(d, ack);
            check("data ack", i < ok_n, ack);
            lo = wa[2:0] + i[2:0];
            if (i < ok_n) ref_mem[{wa[7:3], lo}] = keep ? int'(d) : -1;
        end
        u_bus.stop();
        if (keep) begin
            check("write_busy", 1, write_busy);
            u_bus.start();
            u_bus.wbyte({kind, strap, 1'b0}, ack);
            check("busy address ack", 0, ack);
            u_bus.stop();
        end
        wait_idle();
    endtask

    task automatic rd(input logic [3:0] kind, input logic [7:0] wa,
                      input int n);
        logic ack;
        logic [7:0] d;
        logic [7:0] a;
        u_bus.start();
        u_bus.wbyte({kind, strap, 1'b0}, ack);
        check("address ack", 1, ack);
        u_bus.wbyte(wa, ack);
        check("word ack", 1, ack);
        u_bus.start();
        u_bus.wbyte({kind, strap, 1'b1}, ack);
        check("read address ack", 1, ack);
        for (int i = 0; i < n; i++) begin
            u_bus.rbyte(i < n - 1, d);
            a = wa + i[7:0];
            if (kind == eeprom_pkg::SN_TYPE) begin
                check("sn byte", sn_value[8 * (15 - a[3:0]) +: 8], d);
            end else if (ref_mem[a] >= 0) begin
                check("array byte", ref_mem[a], d);
            end
        end
        u_bus.stop();
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic ack;
        logic [3:0] kind;
        for (int i = 0; i < 256; i++) ref_mem[i] = -1;
        @(negedge clk);
        seed = xs(seed);
        strap = seed[2:0];
        pb = {seed[12:8], 3'h0};
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        check("sda_oe after reset", 0, sda_oe);
        check("write_busy after reset", 0, write_busy);
        for (int i = 1; i < 9; i++) begin
            kind = (i == 8) ? 4'h5 : eeprom_pkg::MEM_TYPE;
            u_bus.start();
            u_bus.wbyte({kind, strap ^ i[2:0], 1'b0}, ack);
            check("foreign address ack", 0, ack);
            u_bus.stop();
        end
        wr(eeprom_pkg::MEM_TYPE, pb, 9, 8, 1'b0);
        wr(eeprom_pkg::MEM_TYPE, pb + 8'h05, 8, 8, 1'b1);
        rd(eeprom_pkg::MEM_TYPE, pb, 8);
        wp = 1'b1;
        wr(eeprom_pkg::MEM_TYPE, pb + 8'h02, 1, 0, 1'b0);
        wp = 1'b0;
        rd(eeprom_pkg::MEM_TYPE, pb + 8'h02, 1);
        wr(eeprom_pkg::MEM_TYPE, pb + 8'h02, 2, 2, 1'b1);
        // Upper half must not alias onto the checked page
        wr(eeprom_pkg::MEM_TYPE, pb ^ 8'h80, 1, 1, 1'b1);
        rd(eeprom_pkg::MEM_TYPE, pb, 8);
        wr(eeprom_pkg::SN_TYPE, 8'h03, 1, 0, 1'b0);
        rd(eeprom_pkg::SN_TYPE, 8'h0E, 3);
        finish_test();
    end

    initial begin
        // Scenarios need about 76k cycles; margin kept under 100k
        repeat (95000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule
